// ===== ffr_top.sv
// transmit fifo flags, receive clock direction and low receive data outputs
// Behaviour
// RQ1: half flag set when transmit fifo holds 128 or more characters
// RQ2: half flag held set while a transmit fifo reset runs
// RQ3: half flag stays deasserted when the transmit fifo is bypassed
// RQ4: half flag floats only while full-chip reset is low
// RQ5: empty flag set when the transmit fifo has nothing for the encoder
// RQ6: empty flag deasserted throughout a transmit fifo reset
// RQ7: in bypass the empty flag means transmitter ready for a character
// RQ8: in self-test empty flag pulses one clock period per sequence end
// RQ9: host keeps its transmit clock running during self-test
// RQ10: empty flag polarity follows the external-fifo select input
// RQ11: empty flag driven when chip select low, floated when high
// RQ12: with receive fifo enabled the host drives the receive clock
// RQ13: in bypass the device drives a continuous character clock
// RQ14: decoded data shown on low outputs, commands leave them unchanged
// RQ15: with decoder bypassed the raw character low bits are shown
// RQ16: receive data updates on the rising receive clock edge
// RQ17: receive output enable input floats or drives the data outputs
// RQ18: seven low reset samples with write idle start a fifo reset; the code starts it on the eighth qualified sample
// RQ19: self-test runs a 511-character loop and stops fifo reads
// RQ20: transmit fifo holds 256 characters
`default_nettype none
`include "ffr_defs.svh"

module ffr_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  localparam int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  // fill level
  output logic [AW:0] count_o
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ffr_fifo_t;

  ffr_fifo_t q;
  ffr_fifo_t d;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // handshakes from the fill level; clear refuses writes
  assign in_ready_o = (q.cnt != (AW+1)'(DEPTH)) && !clr_i;
  assign out_valid_o = (q.cnt != '0) && !clr_i;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[q.rp];
  assign count_o = q.cnt;

  // pointer and level update
  always_comb
  begin
    d = q;
    if (clr_i)
    begin
      d = '0;
    end
    else
    begin
      if (push)
      begin
        d.wp = q.wp + 1'b1;
      end
      if (pop)
      begin
        d.rp = q.rp + 1'b1;
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage has no reset; pointers do
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[q.wp] <= in_data_i;
    end
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
endmodule

module ffr_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // host transmit side pins
  input wire logic tx_host_clock_i,
  input wire logic reference_clock_i,
  input wire logic tx_fifo_reset_n_i,
  input wire logic tx_write_enable_n_i,
  input wire logic chip_select_n_i,
  input wire logic [7:0] tx_data_i,
  // configuration pins
  input wire logic fifo_bypass_n_i,
  input wire logic tx_selftest_enable_n_i,
  input wire logic external_fifo_polarity_i,
  input wire logic chip_reset_n_i,
  input wire logic codec_bypass_n_i,
  input wire logic rx_output_enable_n_i,
  // transmit status flags
  output logic tx_fifo_half_flag_o,
  output logic tx_fifo_half_flag_oe_o,
  output logic tx_fifo_empty_flag_o,
  output logic tx_fifo_empty_flag_oe_o,
  // two-way receive clock pin
  input wire logic rx_char_clock_i,
  output logic rx_char_clock_o,
  output logic rx_char_clock_oe_o,
  // receive data pins
  output logic [7:0] rx_parallel_data_low_o,
  output logic rx_parallel_data_low_oe_o,
  // encoder side
  output logic [7:0] enc_char_o,
  output logic enc_char_valid_o,
  input wire logic enc_ready_i,
  // decoder side
  input wire logic [7:0] dec_char_i,
  input wire logic dec_cmd_i,
  input wire logic dec_valid_i,
  output logic dec_ready_o
);
  ffr_pkg::ffr_top_t q;
  ffr_pkg::ffr_top_t d;
  ffr_pkg::ffr_pins_t pins;
  logic tx_edge;
  logic ref_edge;
  logic rx_edge;
  logic gen_rise;
  logic bist;
  logic byp;
  logic wr_req;
  logic rst_cond;
  logic empty_raw;
  logic tx_in_ready;
  logic tx_out_valid;
  logic tx_out_ready;
  logic [8:0] tx_count;
  logic rx_out_valid;
  logic [8:0] rx_out_data;

  // gather the asynchronous pins for the synchroniser
  always_comb
  begin
    pins.tx_clk = tx_host_clock_i;
    pins.ref_clk = reference_clock_i;
    pins.rx_clk = rx_char_clock_i;
    pins.rst_n = tx_fifo_reset_n_i;
    pins.wen_n = tx_write_enable_n_i;
    pins.cs_n = chip_select_n_i;
    pins.byp_n = fifo_bypass_n_i;
    pins.bist_n = tx_selftest_enable_n_i;
    pins.ext_pol = external_fifo_polarity_i;
    pins.chip_rst_n = chip_reset_n_i;
    pins.codec_n = codec_bypass_n_i;
    pins.rxoe_n = rx_output_enable_n_i;
    pins.tx_data = tx_data_i;
  end

  // edges seen on the second flop only; data shares the clock's delay
  assign tx_edge = q.s2.tx_clk && !q.tx_clk_prev;
  assign ref_edge = q.s2.ref_clk && !q.ref_clk_prev;
  assign bist = !q.s2.bist_n;
  assign byp = !q.s2.byp_n;
  assign gen_rise = (q.div_cnt == `FFR_RXDIV_LAST) && !q.rx_clk_gen;
  // RQ16: pick receive clock edge
  // RQ12: host clock edge when fifo enabled
  assign rx_edge = byp ? gen_rise : (q.s2.rx_clk && !q.rx_clk_prev);

  // host write taken on a host clock edge outside fifo reset
  assign wr_req = tx_edge && !q.s2.cs_n && !q.s2.wen_n && !q.fifo_rst;
  // RQ18: reset request qualifiers
  assign rst_cond = !q.s2.rst_n && q.s2.wen_n && !q.s2.cs_n && q.s2.byp_n;
  // RQ19: reads stop in self-test
  assign tx_out_ready = enc_ready_i && !bist && !q.fifo_rst;
  assign enc_char_valid_o = tx_out_valid && !bist && !q.fifo_rst;

  // RQ20: 256-character transmit fifo
  ffr_fifo #(
    .W(8),
    .DEPTH(`FFR_TX_DEPTH)
  ) u_tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(q.fifo_rst),
    .in_valid_i(wr_req),
    .in_ready_o(tx_in_ready),
    .in_data_i(q.s2.tx_data),
    .out_valid_o(tx_out_valid),
    .out_ready_i(tx_out_ready),
    .out_data_o(enc_char_o),
    .count_o(tx_count)
  );

  // receive buffer drained one character per receive clock edge
  ffr_fifo #(
    .W(9),
    .DEPTH(`FFR_RX_DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(1'b0),
    .in_valid_i(dec_valid_i),
    .in_ready_o(dec_ready_o),
    .in_data_i({dec_cmd_i, dec_char_i}),
    .out_valid_o(rx_out_valid),
    .out_ready_i(rx_edge),
    .out_data_o(rx_out_data),
    .count_o()
  );

  // raw empty meaning, self-test first, then bypass, then fifo state
  always_comb
  begin
    // RQ8: self-test end pulse
    if (bist)
    begin
      empty_raw = q.bist_pulse;
    end
    // RQ7: transmitter ready in bypass
    else if (byp)
    begin
      empty_raw = enc_ready_i;
    end
    // RQ6: deasserted during fifo reset
    else if (q.fifo_rst)
    begin
      empty_raw = 1'b0;
    end
    // RQ5: nothing to forward
    else
    begin
      empty_raw = !tx_out_valid;
    end
  end

  // next state
  always_comb
  begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.tx_clk_prev = q.s2.tx_clk;
    d.ref_clk_prev = q.s2.ref_clk;
    d.rx_clk_prev = q.s2.rx_clk;
    // RQ18: count seven qualified samples
    if (tx_edge)
    begin
      if (!rst_cond)
      begin
        d.rst_cnt = '0;
      end
      else if (q.rst_cnt != `FFR_RST_SAMPLES)
      begin
        d.rst_cnt = q.rst_cnt + 3'h1;
      end
    end
    // reset holds while the request stays low, ends on the first host clock edge after its release
    if (tx_edge && (q.rst_cnt == `FFR_RST_SAMPLES) && rst_cond)
    begin
      d.fifo_rst = 1'b1;
    end
    else if (tx_edge && q.s2.rst_n)
    begin
      d.fifo_rst = 1'b0;
    end
    if (byp)
    begin
      d.fifo_rst = 1'b0;
      d.rst_cnt = '0;
    end
    // RQ19: 511-character loop on reference edges
    if (!bist)
    begin
      d.bist_cnt = '0;
      d.bist_pulse = 1'b0;
    end
    else if (ref_edge)
    begin
      // RQ8: pulse lasts one reference period
      d.bist_pulse = (q.bist_cnt == `FFR_BIST_LAST);
      d.bist_cnt = d.bist_pulse ? 9'h000 : q.bist_cnt + 9'h001;
    end
    // RQ13: free-running character clock divider
    if (q.div_cnt == `FFR_RXDIV_LAST)
    begin
      d.div_cnt = '0;
      d.rx_clk_gen = !q.rx_clk_gen;
    end
    else
    begin
      d.div_cnt = q.div_cnt + 4'h1;
    end
    d.rx_clk_oe = byp;
    // RQ14: commands leave data alone
    // RQ15: raw low bits in decoder bypass
    if (rx_edge && rx_out_valid && (!q.s2.codec_n || !rx_out_data[8]))
    begin
      d.rx_data = rx_out_data[7:0];
    end
    // RQ17: output enable from its pin
    d.rx_oe = !q.s2.rxoe_n;
    // RQ1: half level from fifo count
    // RQ2: forced set in fifo reset
    // RQ3: held deasserted in bypass
    d.half = !byp && (q.fifo_rst || (tx_count >= `FFR_HALF_LEVEL));
    // RQ4: floats only in full-chip reset
    d.half_oe = q.s2.chip_rst_n;
    // RQ10: polarity select
    d.empty = q.s2.ext_pol ? empty_raw : !empty_raw;
    // RQ11: chip select gates drive
    d.empty_oe = !q.s2.cs_n;
  end

  // single state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign tx_fifo_half_flag_o = q.half;
  assign tx_fifo_half_flag_oe_o = q.half_oe;
  assign tx_fifo_empty_flag_o = q.empty;
  assign tx_fifo_empty_flag_oe_o = q.empty_oe;
  assign rx_char_clock_o = q.rx_clk_gen;
  assign rx_char_clock_oe_o = q.rx_clk_oe;
  assign rx_parallel_data_low_o = q.rx_data;
  assign rx_parallel_data_low_oe_o = q.rx_oe;
endmodule
`default_nettype wire

// ===== ffr_defs.svh
// constants for the transmit flag and receive parallel output block
`ifndef FFR_DEFS_SVH
`define FFR_DEFS_SVH
// transmit fifo depth and half-full level in characters
`define FFR_TX_DEPTH 256
`define FFR_HALF_LEVEL 9'h080
// receive path buffer depth in characters
`define FFR_RX_DEPTH 16
// consecutive host-clock samples counted before the next qualified one starts a fifo reset
`define FFR_RST_SAMPLES 3'h7
// last index of the 511-character self-test sequence
`define FFR_BIST_LAST 9'h1fe
// last divider count of each four-clk_i-cycle half period of the recovered character clock
`define FFR_RXDIV_LAST 4'h3
`endif

// ===== ffr_pkg.sv
// types shared by the transmit flag and receive parallel output block
`default_nettype none
package ffr_pkg;
  // pins from outside the clock domain, synchronised together
  typedef struct packed {
    logic tx_clk;
    logic ref_clk;
    logic rx_clk;
    logic rst_n;
    logic wen_n;
    logic cs_n;
    logic byp_n;
    logic bist_n;
    logic ext_pol;
    logic chip_rst_n;
    logic codec_n;
    logic rxoe_n;
    logic [7:0] tx_data;
  } ffr_pins_t;

  // complete state of the top module
  typedef struct packed {
    ffr_pins_t s1;
    ffr_pins_t s2;
    logic tx_clk_prev;
    logic ref_clk_prev;
    logic rx_clk_prev;
    logic [2:0] rst_cnt;
    logic fifo_rst;
    logic [8:0] bist_cnt;
    logic bist_pulse;
    logic [3:0] div_cnt;
    logic rx_clk_gen;
    logic [7:0] rx_data;
    logic half;
    logic half_oe;
    logic empty;
    logic empty_oe;
    logic rx_clk_oe;
    logic rx_oe;
  } ffr_top_t;
endpackage
`default_nettype wire

// ===== ffr_checker.sv
// assertion checker for the transmit flag and receive output block
`default_nettype none
module ffr_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched pins
  input wire logic fifo_bypass_n_i,
  input wire logic tx_selftest_enable_n_i,
  input wire logic external_fifo_polarity_i,
  input wire logic chip_reset_n_i,
  input wire logic chip_select_n_i,
  input wire logic rx_output_enable_n_i,
  input wire logic enc_ready_i,
  input wire logic tx_fifo_half_flag_o,
  input wire logic tx_fifo_half_flag_oe_o,
  input wire logic tx_fifo_empty_flag_o,
  input wire logic tx_fifo_empty_flag_oe_o,
  input wire logic rx_char_clock_o,
  input wire logic rx_char_clock_oe_o,
  input wire logic [7:0] rx_parallel_data_low_o,
  input wire logic rx_parallel_data_low_oe_o
);
  // six stable samples cover the three-flop pin latency
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  half_float_a: assert property (
    $stable(chip_reset_n_i)[*6] |-> tx_fifo_half_flag_oe_o == chip_reset_n_i)
    else $error("half flag enable wrong");
  empty_float_a: assert property (
    $stable(chip_select_n_i)[*6] |-> tx_fifo_empty_flag_oe_o == !chip_select_n_i)
    else $error("empty flag enable wrong");
  bypass_half_a: assert property (
    !fifo_bypass_n_i[*6] |-> !tx_fifo_half_flag_o) else $error("half flag set in bypass");
  bypass_ready_a: assert property (
    (!fifo_bypass_n_i && tx_selftest_enable_n_i
      && $stable({enc_ready_i, external_fifo_polarity_i}))[*6]
    |-> tx_fifo_empty_flag_o == (enc_ready_i == external_fifo_polarity_i))
    else $error("empty flag not ready in bypass");
  rx_char_clock_dir_a: assert property (
    $stable(fifo_bypass_n_i)[*6] |-> rx_char_clock_oe_o == !fifo_bypass_n_i)
    else $error("rx clock direction wrong");
  rx_char_clock_high_a: assert property (disable iff (rst_i || fifo_bypass_n_i)
    $rose(rx_char_clock_o) |-> rx_char_clock_o[*4] ##1 !rx_char_clock_o)
    else $error("rx clock high time wrong");
  rx_char_clock_low_a: assert property (disable iff (rst_i || fifo_bypass_n_i)
    $fell(rx_char_clock_o) |-> !rx_char_clock_o[*4] ##1 rx_char_clock_o)
    else $error("rx clock stopped");
  rxdata_oe_a: assert property (
    $stable(rx_output_enable_n_i)[*6] |-> rx_parallel_data_low_oe_o == !rx_output_enable_n_i)
    else $error("rx data enable wrong");
  rxdata_edge_a: assert property (disable iff (rst_i || fifo_bypass_n_i)
    $changed(rx_parallel_data_low_o) |-> $rose(rx_char_clock_o))
    else $error("rx data moved off clock edge");
  // main scenarios reached
  cover property ($rose(tx_fifo_half_flag_o));
  cover property ($rose(rx_char_clock_o));
  cover property ($changed(rx_parallel_data_low_o));
endmodule
`default_nettype wire

// ===== ffr_host_model.sv
// host model driving transmit pins and the receive input clock
`default_nettype none
module ffr_host_model (
  // pins toward the block
  output logic tx_host_clock_o,
  output logic tx_write_enable_n_o,
  output logic tx_fifo_reset_n_o,
  output logic [7:0] tx_data_o,
  output logic rx_clk_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle pins, clock stands still outside transfers
  initial
  begin
    tx_host_clock_o = 1'b0;
    tx_write_enable_n_o = 1'b1;
    tx_fifo_reset_n_o = 1'b1;
    tx_data_o = 8'h00;
    rx_clk_o = 1'b0;
  end
  // one 125 ns host clock period; data inverted once released
  task automatic cyc(input logic wen_n, input logic rst_n, input logic [7:0] d);
    tx_write_enable_n_o = wen_n;
    tx_fifo_reset_n_o = rst_n;
    tx_data_o = d;
    #62.5 tx_host_clock_o = 1'b1;
    // release mid-high so back-to-back calls never touch a pin twice at once
    #31.25 tx_write_enable_n_o = 1'b1;
    tx_data_o = ~d;
    #31.25 tx_host_clock_o = 1'b0;
  endtask
  task automatic fifo_reset();
    repeat (8) cyc(1'b1, 1'b0, 8'h00);
  endtask
  task automatic run(input int n);
    repeat (n) cyc(1'b1, 1'b1, 8'h00);
  endtask
  task automatic rx_pulse();
    #62.5 rx_clk_o = 1'b1;
    #62.5 rx_clk_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== ffr_top_tb_top.sv
// testbench for the transmit flag and receive output block
`default_nettype none
module ffr_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0, rst_i = 1'b1, reference_clock_i = 1'b0;
  logic fifo_bypass_n_i = 1'b1, tx_selftest_enable_n_i = 1'b1, external_fifo_polarity_i = 1'b1;
  logic chip_reset_n_i = 1'b1, codec_bypass_n_i = 1'b1, rx_output_enable_n_i = 1'b0;
  logic chip_select_n_i = 1'b0, enc_ready_i = 1'b0, dec_cmd_i = 1'b0, dec_valid_i = 1'b0;
  logic [7:0] dec_char_i = 8'h00, tx_data_i, rx_parallel_data_low_o, enc_char_o, ex;
  logic tx_host_clock_i, tx_write_enable_n_i, tx_fifo_reset_n_i, hrx, enc_char_valid_o;
  logic tx_fifo_half_flag_o, tx_fifo_half_flag_oe_o, tx_fifo_empty_flag_o;
  logic tx_fifo_empty_flag_oe_o, rx_char_clock_o, rx_char_clock_oe_o;
  logic rx_parallel_data_low_oe_o, dec_ready_o;
  wire logic rx_char_clock_i = rx_char_clock_oe_o ? rx_char_clock_o : hrx;
  int errors = 0, compares = 0, n1, n2;
  // rows: bypass, chip reset, select, rx enable, polarity | oe flags, empty, half
  localparam logic [10:0] ROWS [4] = '{11'h676, 11'h580, 11'h2f8, 11'h10e};
  ffr_top DUT (.*);
  ffr_host_model host (.tx_host_clock_o(tx_host_clock_i), .tx_write_enable_n_o(tx_write_enable_n_i),
    .tx_fifo_reset_n_o(tx_fifo_reset_n_i), .tx_data_o(tx_data_i), .rx_clk_o(hrx));
  // system and free-running reference clocks
  always #5 clk_i = ~clk_i;
  always #40 reference_clock_i = ~reference_clock_i;
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // offer one decoder character, hold until taken
  task automatic push(input logic [7:0] c, input logic m);
    dec_char_i <= c;
    dec_cmd_i <= m;
    dec_valid_i <= 1'b1;
    @(negedge clk_i);
    while (dec_ready_o !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  // hang guard, well past the expected run
  initial
  begin
    #400us;
    errors++;
    conclude();
  end
  initial
  begin
    wt(7);
    chk("reset", {tx_fifo_half_flag_o, tx_fifo_half_flag_oe_o, tx_fifo_empty_flag_oe_o,
      rx_char_clock_oe_o, rx_parallel_data_low_oe_o, dec_ready_o, rx_parallel_data_low_o}, 16'h0100);
    @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ROWS[i])
    begin
      @(posedge clk_i);
      {fifo_bypass_n_i, chip_reset_n_i, chip_select_n_i, rx_output_enable_n_i,
        external_fifo_polarity_i} <= ROWS[i][10:6];
      wt(10);
      chk("row", {tx_fifo_half_flag_oe_o, tx_fifo_empty_flag_oe_o, rx_char_clock_oe_o,
        rx_parallel_data_low_oe_o, tx_fifo_empty_flag_o, tx_fifo_half_flag_o}, ROWS[i][5:0]);
    end
    @(posedge clk_i);
    {fifo_bypass_n_i, chip_reset_n_i, chip_select_n_i, rx_output_enable_n_i} <= 4'hc;
    external_fifo_polarity_i <= 1'b1;
    host.fifo_reset();
    wt(8);
    chk("in reset", {tx_fifo_half_flag_o, tx_fifo_empty_flag_o}, 16'h2);
    host.cyc(1'b1, 1'b1, 8'h00);
    wt(8);
    chk("after reset", {tx_fifo_half_flag_o, tx_fifo_empty_flag_o}, 16'h1);
    for (int i = 0; i < 127; i++) host.cyc(1'b0, 1'b1, 8'(i));
    wt(8);
    chk("127 held", {tx_fifo_half_flag_o, tx_fifo_empty_flag_o}, 16'h0);
    host.cyc(1'b0, 1'b1, 8'h7f);
    wt(8);
    chk("128 held", tx_fifo_half_flag_o, 16'h1);
    chk("head", {enc_char_valid_o, enc_char_o}, 16'h0100);
    @(posedge clk_i);
    enc_ready_i <= 1'b1;
    wt(300);
    chk("drained", {tx_fifo_half_flag_o, tx_fifo_empty_flag_o}, 16'h1);
    @(posedge clk_i);
    enc_ready_i <= 1'b0;
    for (int i = 0; i < 16; i++) push(8'h40 + 8'(i), i == 5);
    dec_valid_i <= 1'b0;
    wt(2);
    chk("rx full", dec_ready_o, 16'h0);
    ex = 8'h00;
    for (int i = 0; i < 16; i++)
    begin
      host.rx_pulse();
      wt(12);
      if (i != 5)
        ex = 8'h40 + 8'(i);
      chk("rx data", rx_parallel_data_low_o, ex);
    end
    @(posedge clk_i);
    codec_bypass_n_i <= 1'b0;
    push(8'h5a, 1'b1);
    dec_valid_i <= 1'b0;
    host.rx_pulse();
    wt(12);
    chk("raw char", rx_parallel_data_low_o, 16'h5a);
    @(posedge clk_i);
    fifo_bypass_n_i <= 1'b0;
    codec_bypass_n_i <= 1'b1;
    wt(8);
    @(posedge clk_i);
    push(8'ha5, 1'b0);
    dec_valid_i <= 1'b0;
    wt(30);
    chk("bypass data", rx_parallel_data_low_o, 16'ha5);
    @(posedge clk_i);
    enc_ready_i <= 1'b1;
    wt(4);
    chk("bypass ready", tx_fifo_empty_flag_o, 16'h1);
    @(posedge clk_i);
    enc_ready_i <= 1'b0;
    fifo_bypass_n_i <= 1'b1;
    tx_selftest_enable_n_i <= 1'b0;
    fork
      host.run(400);
      begin
        wt(20);
        n1 = 0;
        n2 = 0;
        // wait for the end of the first 511-character loop
        while (tx_fifo_empty_flag_o !== 1'b1 && n2 < 6000)
        begin
          wt(0);
          n2++;
        end
        // pulse width in system cycles, one reference period expected
        while (tx_fifo_empty_flag_o === 1'b1 && n1 < 50)
        begin
          wt(0);
          n1++;
        end
      end
    join
    chk("bist loop", 16'(n2 > 3900 && n2 < 4300), 16'h1);
    chk("bist pulse", 16'(n1), 16'h0008);
    conclude();
  end
endmodule
bind ffr_top ffr_checker u_chk (.*);
`default_nettype wire
